//--- pit_pkg.sv
// Package with register map, field layout and reset values of the periodic interrupt timer.
`default_nettype none
package pit_pkg;
  // Register offsets on the 8-bit register port.
  localparam logic [2:0] OFF_STATUS_CONTROL = 3'h0;
  localparam logic [2:0] OFF_COUNT_HIGH     = 3'h1;
  localparam logic [2:0] OFF_COUNT_LOW      = 3'h2;
  localparam logic [2:0] OFF_MODULO_HIGH    = 3'h3;
  localparam logic [2:0] OFF_MODULO_LOW     = 3'h4;
  // Field positions in the status and control register.
  localparam int BIT_OVERFLOW_FLAG = 7;
  localparam int BIT_IRQ_ENABLE    = 6;
  localparam int BIT_COUNTER_HALT  = 5;
  localparam int BIT_COUNTER_CLEAR = 4;
  localparam int BIT_DIV_SEL_LSB   = 0;
  // Values after reset.
  localparam logic [2:0]  RST_DIV_SEL  = 3'h0;
  localparam logic        RST_HALT     = 1'b1;
  localparam logic [15:0] RST_MODULO   = 16'hffff;
  localparam logic [15:0] RST_COUNT    = 16'h0000;
  // Prescaler width: the largest division is by 64.
  localparam int          PRESCALE_W   = 6;
endpackage : pit_pkg
`default_nettype wire

//--- pit_timer.sv
// Periodic interrupt timer: prescaler, 16-bit modulo up-counter and register port.
// Function
// R1: 16-bit up-counter, free or modulo count.
// R2: Counter reads never disturb counting.
// R3: Three-bit select divides bus clock 1 to 64.
// R4: Match sets flag, restarts from zero.
// R5: Flag clears by read-then-write-zero, overflow wins.
// R6: Writing one to flag does nothing.
// R7: Enable bit allows interrupt on flag.
// R8: Halt bit freezes counter, set at reset.
// R9: Clear bit zeroes counter and prescaler.
// R10: Halt plus clear holds counter at zero.
// R11: High-byte read latches low byte.
// R12: Resets zero the readable counter bytes.
// R13: Modulo high write suppresses flag until low.
// R14: Modulo resets to all ones.
// R15: Software clears counter before modulo writes.
// R16: Wait mode keeps counting, interrupt wakes.
// R17: Software leaves halt clear for wait wakeup.
// R18: Stop mode halts, keeps all state.
// R19: Debug break halts the counter.
// R20: Break without clear enable protects flags.
// R21: Break with clear enable allows clearing.
// R22: Low-byte latch survives break end.
// R23: Interrupt is level of flag and enable.
// R24: Prescaler is a count enable divider.
//
// Implementation choices: the register offsets and the strobed register port.
`default_nettype none
module pit_timer (
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       reset,
  // Register port.
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  // System mode inputs.
  input  wire logic       stop_mode,
  input  wire logic       debug_break,
  input  wire logic       break_flag_clear_enable,
  // Interrupt request.
  output logic            irq
);

  // Control and status state.
  logic                            overflow_flag;
  logic                            overflow_irq_enable;
  logic                            counter_halt;
  logic [2:0]                      clock_divider_select;
  logic [15:0]                     count;
  logic [15:0]                     modulo;
  logic [7:0]                      modulo_high_buf;
  logic                            modulo_pending;
  logic                            clear_armed;
  logic [7:0]                      low_latch;
  logic                            low_latched;
  logic [pit_pkg::PRESCALE_W-1:0]  prescale;

  // Register decode; flag protection applies while a break hides flag changes.
  wire flags_locked = debug_break & ~break_flag_clear_enable;
  wire wr_ctrl      = reg_write & (reg_addr == pit_pkg::OFF_STATUS_CONTROL);
  wire rd_ctrl      = reg_read  & (reg_addr == pit_pkg::OFF_STATUS_CONTROL);
  wire rd_high      = reg_read  & (reg_addr == pit_pkg::OFF_COUNT_HIGH);
  wire rd_low       = reg_read  & (reg_addr == pit_pkg::OFF_COUNT_LOW);
  wire wr_mod_high  = reg_write & (reg_addr == pit_pkg::OFF_MODULO_HIGH);
  wire wr_mod_low   = reg_write & (reg_addr == pit_pkg::OFF_MODULO_LOW);
  wire clear_cmd    = wr_ctrl & reg_wdata[pit_pkg::BIT_COUNTER_CLEAR];  // R9

  // Counting stops for halt bit, stop mode or a debug break; wait mode is not a stop.
  wire run          = ~counter_halt & ~stop_mode & ~debug_break;  // R8 R16 R18 R19

  // Prescaler tap: the low k bits all ones gives one enable in 2**k cycles.
  logic [pit_pkg::PRESCALE_W-1:0] tap_mask;
  always_comb begin
    case (clock_divider_select)  // R3
      3'h0:    tap_mask = 6'h00;
      3'h1:    tap_mask = 6'h01;
      3'h2:    tap_mask = 6'h03;
      3'h3:    tap_mask = 6'h07;
      3'h4:    tap_mask = 6'h0f;
      3'h5:    tap_mask = 6'h1f;
      default: tap_mask = 6'h3f;
    endcase
  end
  wire count_en     = run & ((prescale & tap_mask) == tap_mask);  // R24
  wire at_modulo    = (count == modulo);
  wire overflow_evt = count_en & at_modulo;  // R4
  // A modulo update in progress hides the overflow from the flag.
  wire flag_set     = overflow_evt & ~modulo_pending;  // R13
  // Second step of the clear: armed read earlier, zero written now.
  wire flag_clear   = wr_ctrl & ~reg_wdata[pit_pkg::BIT_OVERFLOW_FLAG] & clear_armed
                      & ~flags_locked;  // R5 R20 R21

  // Prescaler runs freely while counting and restarts on the clear command.
  always_ff @(posedge core_clk) begin
    if (reset || clear_cmd) begin  // R9
      prescale <= '0;
    end else if (run) begin
      prescale <= prescale + 1'b1;
    end
  end

  // Counter; reads play no part here so they cannot disturb the sequence.
  always_ff @(posedge core_clk) begin
    if (reset || clear_cmd) begin  // R9 R10 R12
      count <= pit_pkg::RST_COUNT;
    end else if (overflow_evt) begin  // R4
      count <= 16'h0000;
    end else if (count_en) begin  // R1 R2
      count <= count + 16'h0001;
    end
  end

  // Overflow flag; a new overflow beats the clear and drops the armed read.
  always_ff @(posedge core_clk) begin
    if (reset) begin  // R6
      overflow_flag <= 1'b0;
      clear_armed   <= 1'b0;
    end else begin
      if (flag_set) begin  // R5
        overflow_flag <= 1'b1;
        clear_armed   <= 1'b0;
      end else if (flag_clear) begin  // R5 R6
        overflow_flag <= 1'b0;
        clear_armed   <= 1'b0;
      end else if (rd_ctrl && overflow_flag && !flags_locked) begin  // R20
        clear_armed   <= 1'b1;
      end
    end
  end

  // Control fields; the clear bit is not stored and reads back as zero.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      overflow_irq_enable  <= 1'b0;  // R7
      counter_halt         <= pit_pkg::RST_HALT;  // R8
      clock_divider_select <= pit_pkg::RST_DIV_SEL;  // R3
    end else if (wr_ctrl) begin
      overflow_irq_enable  <= reg_wdata[pit_pkg::BIT_IRQ_ENABLE];
      counter_halt         <= reg_wdata[pit_pkg::BIT_COUNTER_HALT];  // R8 R10
      clock_divider_select <= reg_wdata[pit_pkg::BIT_DIV_SEL_LSB +: 3];
    end
  end

  // Modulo is taken as a pair so the counter never sees a half-written value.
  always_ff @(posedge core_clk) begin
    if (reset) begin  // R14
      modulo          <= pit_pkg::RST_MODULO;
      modulo_high_buf <= pit_pkg::RST_MODULO[15:8];
      modulo_pending  <= 1'b0;
    end else if (wr_mod_high) begin  // R13
      modulo_high_buf <= reg_wdata;
      modulo_pending  <= 1'b1;
    end else if (wr_mod_low) begin  // R13
      modulo          <= {modulo_high_buf, reg_wdata};
      modulo_pending  <= 1'b0;
    end
  end

  // Low-byte latch; held until the low byte is read or the clear bit is written, break or not.
  always_ff @(posedge core_clk) begin
    if (reset || clear_cmd) begin  // R12
      low_latch   <= 8'h00;
      low_latched <= 1'b0;
    end else if (rd_high && !low_latched) begin  // R11
      low_latch   <= count[7:0];
      low_latched <= 1'b1;
    end else if (rd_low) begin  // R11 R22
      low_latched <= 1'b0;
    end
  end

  // Read data selection.
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      pit_pkg::OFF_STATUS_CONTROL:
        rd_mux = {overflow_flag, overflow_irq_enable, counter_halt, 1'b0, 1'b0,
                  clock_divider_select};
      pit_pkg::OFF_COUNT_HIGH:  rd_mux = count[15:8];
      pit_pkg::OFF_COUNT_LOW:   rd_mux = low_latched ? low_latch : count[7:0];  // R11
      pit_pkg::OFF_MODULO_HIGH: rd_mux = modulo_pending ? modulo_high_buf : modulo[15:8];
      pit_pkg::OFF_MODULO_LOW:  rd_mux = modulo[7:0];
      default:                  rd_mux = 8'h00;
    endcase
  end

  // Registered read data and interrupt level; the level still wakes wait mode.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
      irq       <= 1'b0;
    end else begin
      reg_rdata <= reg_read ? rd_mux : 8'h00;
      irq       <= (overflow_flag | flag_set) & overflow_irq_enable;  // R7 R16 R23
    end
  end

  // Helper: previous count for checks.
  logic [15:0] count_q;
  always_ff @(posedge core_clk) begin
    count_q <= count;
  end

  property p_halt_freezes;
    @(posedge core_clk) disable iff (reset)
      (counter_halt && !clear_cmd) |=> (count == $past(count));
  endproperty
  a_halt_freezes: assert property (p_halt_freezes) else $error("count moved while halted"); // R8

  property p_break_freezes;
    @(posedge core_clk) disable iff (reset)
      (debug_break && !clear_cmd) |=> $stable(count);
  endproperty
  a_break_freezes: assert property (p_break_freezes) else $error("count moved in break"); // R19

  property p_clear_zero;
    @(posedge core_clk) disable iff (reset)
      clear_cmd |=> (count == 16'h0000) && (prescale == '0);
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("clear did not zero"); // R9

  property p_wrap;
    @(posedge core_clk) disable iff (reset)
      (overflow_evt && !clear_cmd) |=> (count == 16'h0000);
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap at modulo"); // R4

  property p_flag_set;
    @(posedge core_clk) disable iff (reset)
      (overflow_evt && !modulo_pending) |=> overflow_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set"); // R4

  sequence s_flag_drop;
    overflow_flag ##1 !overflow_flag;
  endsequence
  property p_flag_clear_cause;
    @(posedge core_clk) disable iff (reset)
      s_flag_drop |-> $past(flag_clear);
  endproperty
  a_flag_clear_cause: assert property (p_flag_clear_cause) else $error("bad flag clear"); // R5

  property p_pending_block;
    @(posedge core_clk) disable iff (reset)
      (modulo_pending && !overflow_flag && !flag_set) |=> !overflow_flag;
  endproperty
  a_pending_block: assert property (p_pending_block) else $error("flag set while pending"); // R13

  property p_irq_level;
    @(posedge core_clk) disable iff (reset)
      (overflow_flag && overflow_irq_enable) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq missing"); // R23

  property p_latch_hold;
    @(posedge core_clk) disable iff (reset)
      (low_latched && !rd_low && !clear_cmd) |=> $stable(low_latch) && low_latched;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch changed"); // R11

  property p_step;
    @(posedge core_clk) disable iff (reset)
      (count_en && !at_modulo && !clear_cmd) |=> (count == count_q + 16'h0001);
  endproperty
  a_step: assert property (p_step) else $error("count step wrong"); // R1

  // Checks on reset values, the prescaler, break protection and read side effects.
  property p_reset_count;
    @(posedge core_clk)
      reset |=> (count == 16'h0000) && !low_latched && (reg_rdata == 8'h00) && !irq;
  endproperty
  a_reset_count: assert property (p_reset_count) else $error("reset left count"); // R12

  property p_reset_ctrl;
    @(posedge core_clk)
      reset |=> (modulo == pit_pkg::RST_MODULO) && (counter_halt == pit_pkg::RST_HALT)
                && (clock_divider_select == pit_pkg::RST_DIV_SEL) && !modulo_pending
                && !overflow_flag && !overflow_irq_enable;
  endproperty
  a_reset_ctrl: assert property (p_reset_ctrl) else $error("reset left control"); // R14

  property p_prescale_step;
    @(posedge core_clk) disable iff (reset)
      (run && !clear_cmd) |=> (prescale == $past(prescale) + 6'h01);
  endproperty
  a_prescale_step: assert property (p_prescale_step) else $error("prescaler stalled"); // R24

  property p_one_write;
    @(posedge core_clk) disable iff (reset)
      (wr_ctrl && reg_wdata[pit_pkg::BIT_OVERFLOW_FLAG] && !overflow_flag && !flag_set)
        |=> !overflow_flag;
  endproperty
  a_one_write: assert property (p_one_write) else $error("flag set by write"); // R6

  property p_irq_off;
    @(posedge core_clk) disable iff (reset)
      !overflow_irq_enable |=> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled"); // R7

  property p_irq_drop;
    @(posedge core_clk) disable iff (reset)
      (!overflow_flag && !flag_set) |=> !irq;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("irq without flag"); // R23

  property p_stop_freeze;
    @(posedge core_clk) disable iff (reset)
      (stop_mode && !clear_cmd) |=> $stable(count) && $stable(prescale);
  endproperty
  a_stop_freeze: assert property (p_stop_freeze) else $error("count moved in stop"); // R18

  property p_locked_no_arm;
    @(posedge core_clk) disable iff (reset)
      (flags_locked && !clear_armed) |=> !clear_armed;
  endproperty
  a_locked_no_arm: assert property (p_locked_no_arm) else $error("armed in break"); // R20

  property p_locked_keep;
    @(posedge core_clk) disable iff (reset)
      (flags_locked && overflow_flag) |=> overflow_flag;
  endproperty
  a_locked_keep: assert property (p_locked_keep) else $error("flag cleared in break"); // R20

  property p_locked_pending;
    @(posedge core_clk) disable iff (reset)
      (flags_locked && clear_armed && !flag_set) |=> clear_armed;
  endproperty
  a_locked_pending: assert property (p_locked_pending) else $error("armed step lost"); // R20

  property p_break_clear;
    @(posedge core_clk) disable iff (reset)
      (debug_break && break_flag_clear_enable && flag_clear && !flag_set) |=> !overflow_flag;
  endproperty
  a_break_clear: assert property (p_break_clear) else $error("break clear refused"); // R21

  property p_break_latch;
    @(posedge core_clk) disable iff (reset)
      (debug_break && low_latched && !rd_low && !clear_cmd) |=> low_latched;
  endproperty
  a_break_latch: assert property (p_break_latch) else $error("latch lost in break"); // R22

  property p_read_quiet;
    @(posedge core_clk) disable iff (reset)
      (reg_read && !reg_write && !count_en) |=> $stable(count);
  endproperty
  a_read_quiet: assert property (p_read_quiet) else $error("read moved count"); // R2

  sequence s_held_zero;
    (count == 16'h0000) ##1 (count == 16'h0000);
  endsequence
  property p_halt_clear;
    @(posedge core_clk) disable iff (reset)
      (clear_cmd && reg_wdata[pit_pkg::BIT_COUNTER_HALT]) |=> s_held_zero;
  endproperty
  a_halt_clear: assert property (p_halt_clear) else $error("halted clear not zero"); // R10

endmodule : pit_timer
`default_nettype wire

//--- pit_timer_test.sv
// Self-checking bench for the periodic interrupt timer.
`default_nettype none
module pit_timer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk;
  logic        reset;
  logic        reg_write;
  logic        reg_read;
  logic        stop_mode;
  logic        debug_break;
  logic        flag_clr_en;
  logic        irq;
  logic [2:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic [7:0]  d;
  logic [15:0] v;
  logic [15:0] w;
  int          bad_count = 0;
  int          n_checks = 0;
  int          cycles = 0;

  pit_timer dut_u (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .stop_mode(stop_mode), .debug_break(debug_break),
    .break_flag_clear_enable(flag_clr_en), .irq(irq));

  // Free-running 100 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Cycle count read by the watchdog branch of the main sequence.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
  end

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // Strobes drop for one cycle between accesses so no signal is driven twice per step.
  task automatic wr(input logic [2:0] a, input logic [7:0] x);
    reg_addr  <= a;
    reg_wdata <= x;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
    @(posedge core_clk);
  endtask : wr

  // Read data is registered, so it is sampled just after the taking edge.
  task automatic rd(input logic [2:0] a, output logic [7:0] q);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 q = reg_rdata;
    @(posedge core_clk);
  endtask : rd

  task automatic wc(input logic [7:0] x);
    wr(pit_pkg::OFF_STATUS_CONTROL, x);
  endtask : wc

  task automatic rc(input logic [7:0] exp);
    rd(pit_pkg::OFF_STATUS_CONTROL, d);
    check("ctrl", {8'h00, d}, {8'h00, exp});
  endtask : rc

  task automatic cnt(output logic [15:0] q);
    rd(pit_pkg::OFF_COUNT_HIGH, q[15:8]);
    rd(pit_pkg::OFF_COUNT_LOW, q[7:0]);
  endtask : cnt

  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    check("irq", {15'h0, irq}, 16'h1);
  endtask : wait_irq

  task automatic t_reset;
    rc(8'h20);
    wr(pit_pkg::OFF_COUNT_HIGH, 8'h55);
    cnt(v);
    check("count", v, pit_pkg::RST_COUNT);
    rd(pit_pkg::OFF_MODULO_HIGH, v[15:8]);
    rd(pit_pkg::OFF_MODULO_LOW, v[7:0]);
    check("modulo", v, pit_pkg::RST_MODULO);
    rd(3'h5, d);
    check("unmapped", {8'h00, d}, 16'h0000);
  endtask : t_reset

  // Short modulo, then the two-step flag clear with its refused variants.
  task automatic t_overflow;
    wc(8'h30);
    wr(pit_pkg::OFF_MODULO_HIGH, 8'h00);
    wr(pit_pkg::OFF_MODULO_LOW, 8'h03);
    wc(8'h40);
    wait_irq();
    wc(8'he0);
    cnt(v);
    check("wrap", {15'h0, v <= 16'h0003}, 16'h1);
    wc(8'h60);
    rc(8'he0);
    check("irq held", {15'h0, irq}, 16'h1);
    wc(8'h60);
    rc(8'h60);
    check("irq low", {15'h0, irq}, 16'h0);
  endtask : t_overflow

  task automatic waitc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : waitc

  task automatic t_break;
    wc(8'h30);
    wr(pit_pkg::OFF_MODULO_HIGH, 8'h00);
    wc(8'h40);
    waitc(30);
    check("suppressed", {15'h0, irq}, 16'h0);
    wr(pit_pkg::OFF_MODULO_LOW, 8'h03);
    wait_irq();
    debug_break <= 1'b1;
    rc(8'hc0);
    wc(8'h60);
    debug_break <= 1'b0;
    rc(8'he0);
    debug_break <= 1'b1;
    waitc(5);
    debug_break <= 1'b0;
    wc(8'h60);
    rc(8'h60);
    wc(8'h40);
    wait_irq();
    flag_clr_en <= 1'b1;
    debug_break <= 1'b1;
    rc(8'hc0);
    wc(8'h60);
    debug_break <= 1'b0;
    rc(8'h60);
    flag_clr_en <= 1'b0;
  endtask : t_break

  // Each select runs 256 bus clocks from a cleared prescaler.
  task automatic t_prescale;
    int dv;
    wc(8'h30);
    wr(pit_pkg::OFF_MODULO_HIGH, 8'hff);
    wr(pit_pkg::OFF_MODULO_LOW, 8'hff);
    for (int s = 0; s < 8; s++) begin
      dv = (s > 5) ? 64 : (1 << s);
      wc(8'h30);
      wc(8'(s));
      waitc(256);
      wc(8'h20 | 8'(s));
      cnt(v);
      check("divided", {15'h0, v >= 16'(256 / dv - 1) && v <= 16'(262 / dv + 1)}, 16'h1);
    end
  endtask : t_prescale

  task automatic t_latch;
    wc(8'h30);
    wc(8'h00);
    rd(pit_pkg::OFF_COUNT_HIGH, v[15:8]);
    waitc(100);
    rd(pit_pkg::OFF_COUNT_HIGH, v[15:8]);
    rd(pit_pkg::OFF_COUNT_LOW, v[7:0]);
    wc(8'h20);
    cnt(w);
    check("latched", {15'h0, (w - v) >= 16'd100 && (w - v) <= 16'd115}, 16'h1);
  endtask : t_latch

  task automatic t_clear;
    wc(8'h00);
    waitc(30);
    wc(8'h30);
    waitc(20);
    cnt(v);
    check("halted zero", v, 16'h0000);
    rc(8'h20);
    wc(8'h10);
    cnt(v);
    check("restart", {15'h0, v <= 16'd8}, 16'h1);
  endtask : t_clear

  task automatic t_modes;
    for (int m = 1; m < 3; m++) begin
      {debug_break, stop_mode} <= 2'(m);
      @(posedge core_clk);
      cnt(v);
      waitc(40);
      cnt(w);
      check("frozen", w, v);
      {debug_break, stop_mode} <= 2'b00;
      waitc(10);
      cnt(v);
      check("resumed", {15'h0, v > w}, 16'h1);
    end
    wc(8'h20);
  endtask : t_modes

  // Reset for 16 clocks, then the scenarios in turn.
  initial begin
    reset = 1'b1;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    stop_mode = 1'b0;
    debug_break = 1'b0;
    flag_clr_en = 1'b0;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    fork
      begin
        t_reset();
        t_overflow();
        t_break();
        t_prescale();
        t_latch();
        t_clear();
        t_modes();
      end
      begin
        // A hang is cut short here and counted as a mismatch.
        wait (cycles >= 20000);
        bad_count++;
      end
    join_any
    stop_test();
  end
endmodule : pit_timer_test
`default_nettype wire
